// ### design/crcu_pkg.sv
// crcu_pkg: register map, field positions, reset values and fold timing
// of the crc register unit.
// assumes a 32-bit word register port addressed by byte offset.
package crcu_pkg;

  localparam int ADDR_W = 5;

  localparam logic [ADDR_W-1:0] OFF_DATA = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_SPARE = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_INIT = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_GENERATOR_VALUE = 5'h14;

  localparam logic [31:0] RST_DATA = 32'hffffffff;
  localparam logic [31:0] RST_INIT = 32'hffffffff;
  localparam logic [31:0] RST_GENERATOR_VALUE = 32'h04c11db7;
  localparam logic [7:0] RST_SPARE = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // control_word field positions
  localparam int CTL_RELOAD = 0;
  localparam int CTL_SIZE_LO = 3;
  localparam int CTL_INFLIP_LO = 5;
  localparam int CTL_OUTFLIP = 7;
  // writable control bits: 7:3, reload handled apart
  localparam logic [7:0] CTL_KEEP = 8'hf8;

  // generator_size_select codes
  localparam logic [1:0] SZ_32 = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_8 = 2'h2;
  localparam logic [1:0] SZ_7 = 2'h3;

  // input_flip_select codes
  localparam logic [1:0] FLIP_NONE = 2'h0;
  localparam logic [1:0] FLIP_BYTE = 2'h1;
  localparam logic [1:0] FLIP_HALF = 2'h2;
  localparam logic [1:0] FLIP_WORD = 2'h3;

  // fold cycles per input word, one byte per cycle
  localparam logic [2:0] FOLDS_32 = 3'h4;
  localparam logic [2:0] FOLDS_16 = 3'h2;
  localparam logic [2:0] FOLDS_8 = 3'h1;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } crcu_state_e;

  function automatic logic [31:0] crcu_mask(input logic [1:0] sz);
    logic [31:0] m;
    m = 32'hffffffff;
    unique case (sz)
      SZ_32: m = 32'hffffffff;
      SZ_16: m = 32'h0000ffff;
      SZ_8: m = 32'h000000ff;
      SZ_7: m = 32'h0000007f;
    endcase
    return m;
  endfunction

endpackage

// ### design/crcu_fold.sv
// crcu_fold: folds up to eight input bits, msb first, into the crc
// over the width chosen by the size code.
// assumes the data bits sit at the top of dataIn; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module crcu_fold
  import crcu_pkg::*;
(
  input wire logic [31:0] crcIn,
  input wire logic [7:0] dataIn,
  input wire logic [31:0] generator_value,
  input wire logic [1:0] sizeSel,
  output logic [31:0] crcOut
);

  always_comb begin
    logic [31:0] c;
    logic [31:0] m;
    logic fb;
    int top;
    int nBits;
    c = crcIn;
    m = crcu_mask(sizeSel);
    fb = 1'b0;
    top = 31;
    nBits = 8;
    unique case (sizeSel)
      SZ_32: top = 31;
      SZ_16: top = 15;
      SZ_8: top = 7;
      SZ_7: begin
        top = 6;
        nBits = 7;
      end
    endcase
    for (int i = 0; i < 8; i++) begin
      if (i < nBits) begin
        fb = c[top] ^ dataIn[7-i];
        c = (c << 1) & m;
        if (fb) begin
          c = c ^ (generator_value & m);
        end
      end
    end
    crcOut = c;
  end

endmodule
`default_nettype wire

// ### design/crcu_top.sv
// crcu_top: crc register unit with word register port, one-word input
// buffer and a byte-per-cycle folding engine.
// assumes the register port runs on ref_clk and software uses word access.
//
// What this block does
// - words written to the result accumulator feed the crc, not storage.
// - reading the result accumulator returns the crc so far.
// - after reset accumulator and initial value hold all ones.
// - after reset spare byte and control word read zero.
// - spare byte offers eight read-write bits at 7:0.
// - spare byte is independent of the crc, accessible at any time.
// - no control field, reload included, alters the spare byte.
// - control bit 7 bit-reverses the accumulator word on read.
// - control bits 6:5 pick input flip: none, byte, half, word.
// - control bits 4:3 pick generator size 32, 16, 8 or 7.
// - setting control bit 0 reloads the result accumulator.
// - reload copies the initial value into the accumulator.
// - reload bit clears itself after the reload.
// - writing initial value also loads it into the accumulator.
// - fold takes 1, 2 or 4 cycles; input buffer spares the bus.
// - input flips reverse bits inside each group, groups stay put.
// - each new word folds on from the accumulator's present value.
`timescale 1ns/1ps
`default_nettype none
module crcu_top
  import crcu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic busSel,
  input wire logic busWrite,
  input wire logic [crcu_pkg::ADDR_W-1:0] busAddr,
  input wire logic [31:0] busWdata,
  output logic busReady,
  output logic [31:0] busRdata,
  output logic busRvalid
);
  import crcu_pkg::*;

  logic rstMeta_reg, rstSync_n_reg;
  logic [31:0] acc_reg, acc_next;
  logic [31:0] init_reg, init_next;
  logic [31:0] generator_value_reg, generator_value_next;
  logic [7:0] spare_reg, spare_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [31:0] pend_reg, pend_next;
  logic pendValid_reg, pendValid_next;
  logic [31:0] sh_reg, sh_next;
  logic [2:0] cnt_reg, cnt_next;
  crcu_state_e state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  logic [1:0] sizeSel;
  logic [31:0] sizeMask, foldOut, inFlip, outWord;
  logic [31:0] revByte, revHalf, revWord, accRev;
  logic [2:0] foldCount;
  logic [4:0] shiftAmt;
  logic engBusy, stall, take, wr, rd, start;

  // reset release through two flops; assertion is still immediate
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_n_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_n_reg <= rstMeta_reg;
    end
  end

  assign sizeSel = ctrl_reg[CTL_SIZE_LO+1:CTL_SIZE_LO];
  assign sizeMask = crcu_mask(sizeSel);

  // bit reversal inside byte, half-word and word groups
  for (genvar i = 0; i < 32; i++) begin : g_flip
    assign revByte[i] = busWdata[(i/8)*8 + 7 - (i%8)];
    assign revHalf[i] = busWdata[(i/16)*16 + 15 - (i%16)];
    assign revWord[i] = busWdata[31-i];
    assign accRev[i] = outWord[31-i];
  end

  always_comb begin
    unique case (ctrl_reg[CTL_INFLIP_LO+1:CTL_INFLIP_LO])
      FLIP_NONE: inFlip = busWdata;
      FLIP_BYTE: inFlip = revByte;
      FLIP_HALF: inFlip = revHalf;
      FLIP_WORD: inFlip = revWord;
    endcase
  end

  always_comb begin
    unique case (sizeSel)
      SZ_32: begin
        foldCount = FOLDS_32;
        shiftAmt = 5'd0;
      end
      SZ_16: begin
        foldCount = FOLDS_16;
        shiftAmt = 5'd16;
      end
      SZ_8: begin
        foldCount = FOLDS_8;
        shiftAmt = 5'd24;
      end
      SZ_7: begin
        foldCount = FOLDS_8;
        shiftAmt = 5'd25;
      end
    endcase
  end

  assign outWord = acc_reg & sizeMask;

  crcu_fold u_fold (
    .crcIn(acc_reg),
    .dataIn(sh_reg[31:24]),
    .generator_value(generator_value_reg),
    .sizeSel(sizeSel),
    .crcOut(foldOut)
  );

  // a data read waits for the engine so it never sees a half-folded word;
  // spare byte traffic never waits
  assign engBusy = (state_reg == ST_RUN) || pendValid_reg;
  always_comb begin
    stall = 1'b0;
    if (busAddr == OFF_DATA) begin
      stall = busWrite ? pendValid_reg : engBusy;
    end else if (busAddr == OFF_CTRL || busAddr == OFF_INIT ||
                 busAddr == OFF_GENERATOR_VALUE) begin
      stall = engBusy;
    end
  end
  assign busReady = !stall;
  assign take = busSel && !stall;
  assign wr = take && busWrite;
  assign rd = take && !busWrite;
  assign start = (state_reg == ST_IDLE) && pendValid_reg;

  always_comb begin
    acc_next = acc_reg;
    init_next = init_reg;
    generator_value_next = generator_value_reg;
    spare_next = spare_reg;
    ctrl_next = ctrl_reg;
    pend_next = pend_reg;
    pendValid_next = pendValid_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (pendValid_reg) begin
          sh_next = pend_reg << shiftAmt;
          cnt_next = foldCount;
          pendValid_next = 1'b0;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        acc_next = foldOut;
        sh_next = sh_reg << 8;
        cnt_next = cnt_reg - 3'd1;
        if (cnt_reg == 3'd1) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    if (wr) begin
      unique case (busAddr)
        OFF_DATA: begin
          pend_next = inFlip;
          pendValid_next = 1'b1;
        end
        OFF_SPARE: spare_next = busWdata[7:0];
        OFF_CTRL: begin
          // reload bit is never stored, so it reads back as zero
          ctrl_next = busWdata[7:0] & CTL_KEEP;
          if (busWdata[CTL_RELOAD]) begin
            acc_next = init_reg &
                       crcu_mask(busWdata[CTL_SIZE_LO+1:CTL_SIZE_LO]);
          end
        end
        OFF_INIT: begin
          init_next = busWdata;
          acc_next = busWdata & sizeMask;
        end
        OFF_GENERATOR_VALUE: generator_value_next = busWdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_next = 32'h00000000;
    rvalid_next = rd;
    if (rd) begin
      unique case (busAddr)
        OFF_DATA: rdata_next = ctrl_reg[CTL_OUTFLIP] ? accRev : outWord;
        OFF_SPARE: rdata_next = {24'h000000, spare_reg};
        OFF_CTRL: rdata_next = {24'h000000, ctrl_reg};
        OFF_INIT: rdata_next = init_reg;
        OFF_GENERATOR_VALUE: rdata_next = generator_value_reg;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_n_reg) begin
    if (!rstSync_n_reg) begin
      acc_reg <= RST_DATA;
      init_reg <= RST_INIT;
      generator_value_reg <= RST_GENERATOR_VALUE;
      spare_reg <= RST_SPARE;
      ctrl_reg <= RST_CTRL;
      pend_reg <= 32'h00000000;
      pendValid_reg <= 1'b0;
      sh_reg <= 32'h00000000;
      cnt_reg <= 3'h0;
      state_reg <= ST_IDLE;
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      init_reg <= init_next;
      generator_value_reg <= generator_value_next;
      spare_reg <= spare_next;
      ctrl_reg <= ctrl_next;
      pend_reg <= pend_next;
      pendValid_reg <= pendValid_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign busRdata = rdata_reg;
  assign busRvalid = rvalid_reg;

  a_reset_values: assert property (@(posedge ref_clk)
    $rose(rstSync_n_reg) |-> acc_reg == RST_DATA && init_reg == RST_INIT
      && spare_reg == RST_SPARE && ctrl_reg == RST_CTRL)
    else $error("register reset value wrong");

  a_data_not_stored: assert property (@(posedge ref_clk)
    disable iff (!rstSync_n_reg)
    wr && busAddr == OFF_DATA |=> pendValid_reg && acc_reg ==
      ($past(state_reg) == ST_RUN ? $past(foldOut) : $past(acc_reg)))
    else $error("data write stored instead of buffered");

  a_fold_four: assert property (@(posedge ref_clk)
    disable iff (!rstSync_n_reg)
    start && sizeSel == SZ_32 |=> (state_reg == ST_RUN) [*4]
      ##1 state_reg == ST_IDLE)
    else $error("32-bit fold not four cycles");

  a_fold_one: assert property (@(posedge ref_clk)
    disable iff (!rstSync_n_reg)
    start && sizeSel == SZ_8 |=> state_reg == ST_RUN ##1 state_reg == ST_IDLE)
    else $error("8-bit fold not one cycle");

  a_spare_kept: assert property (@(posedge ref_clk)
    disable iff (!rstSync_n_reg)
    wr && busAddr == OFF_CTRL |=> $stable(spare_reg))
    else $error("control write changed spare byte");

  a_reload_copy: assert property (@(posedge ref_clk)
    disable iff (!rstSync_n_reg)
    wr && busAddr == OFF_CTRL && busWdata[CTL_RELOAD]
      |=> acc_reg == ($past(init_reg) & sizeMask) && !ctrl_reg[CTL_RELOAD])
    else $error("reload did not copy initial value");

  a_init_load: assert property (@(posedge ref_clk)
    disable iff (!rstSync_n_reg)
    wr && busAddr == OFF_INIT |=> init_reg == $past(busWdata)
      && acc_reg == ($past(busWdata) & sizeMask))
    else $error("initial value write did not load accumulator");

  a_read_result: assert property (@(posedge ref_clk)
    disable iff (!rstSync_n_reg)
    rd && busAddr == OFF_DATA |=> busRvalid && busRdata ==
      ($past(ctrl_reg[CTL_OUTFLIP]) ? accRev : outWord))
    else $error("accumulator read value wrong");

  a_spare_high: assert property (@(posedge ref_clk)
    disable iff (!rstSync_n_reg)
    rd && busAddr == OFF_SPARE |=> busRdata[31:8] == 24'h000000
      && busRdata[7:0] == $past(spare_reg))
    else $error("spare byte read wrong");

endmodule
`default_nettype wire

// ### verif/crcu_top_tb.sv
// crcu_top_tb: self-checking bench for the crc register unit.
// assumes crcu_pkg and crcu_top are compiled first; the bench drives the
// register port itself and keeps every wait bounded.
`timescale 1ns/1ps
`default_nettype none
module crcu_top_tb;
  import crcu_pkg::*;

  typedef struct packed {
    logic [7:0] ctl;
    logic [31:0] init;
    logic [31:0] d0;
    logic [31:0] d1;
  } crcu_row_s;

  logic refClk;
  logic arstN;
  logic busSel;
  logic busWrite;
  logic [ADDR_W-1:0] busAddr;
  logic [31:0] busWdata;
  logic busReady;
  logic [31:0] busRdata;
  logic busRvalid;
  logic [31:0] acc;
  int errorCnt = 0;
  int nChecks = 0;
  // ctl, init value, first word, second word
  crcu_row_s rows [8] = '{
    '{8'h00, 32'hffffffff, 32'h3456cdef, 32'h00000001},
    '{8'h20, 32'h12345678, 32'h3456cdef, 32'h80000000},
    '{8'h40, 32'h00000000, 32'h3456cdef, 32'hffffffff},
    '{8'he0, 32'hcafe0001, 32'h3456cdef, 32'h0f0f0f0f},
    '{8'h08, 32'h0000ffff, 32'h00001234, 32'h0000abcd},
    '{8'h90, 32'h000000ff, 32'h000000a5, 32'h0000003c},
    '{8'h88, 32'h00000000, 32'h0000ffff, 32'h00000001},
    '{8'h38, 32'h0000007f, 32'h3456cdef, 32'h00000001}};

  crcu_top u_dut (
    .ref_clk(refClk),
    .arst_n(arstN),
    .busSel(busSel),
    .busWrite(busWrite),
    .busAddr(busAddr),
    .busWdata(busWdata),
    .busReady(busReady),
    .busRdata(busRdata),
    .busRvalid(busRvalid)
  );

  initial begin
    refClk = 1'b0;
    forever #2 refClk = ~refClk;
  end

  task automatic endSim();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request is held until ready is sampled high; a clock edge always
  // passes before the next request is raised
  task automatic bus(input logic isWr, input logic [ADDR_W-1:0] addr,
                     input logic [31:0] wd, output logic [31:0] rdOut);
    int n;
    rdOut = 32'h0;
    @(posedge refClk);
    busSel <= 1'b1;
    busWrite <= isWr;
    busAddr <= addr;
    busWdata <= wd;
    // ready is combinational: look mid-cycle, where it has settled, so the
    // register update at the rising edge cannot race the test
    n = 0;
    @(negedge refClk);
    while (busReady !== 1'b1 && n < 40) begin
      @(negedge refClk);
      n++;
    end
    if (busReady !== 1'b1) begin
      errorCnt++;
      $display("CHECK FAILED ready expected 1 seen 0");
      endSim();
    end else begin
      // this rising edge takes the request; release only after it
      @(posedge refClk);
      busSel <= 1'b0;
      if (!isWr) begin
        // read answer stands for the one cycle after the taking edge
        @(negedge refClk);
        check("rvalid", 32'h1, {31'h0, busRvalid});
        rdOut = busRdata;
      end
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdChk(input string what, input logic [ADDR_W-1:0] a,
                       input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(what, exp, x);
  endtask

  task automatic doReset();
    @(posedge refClk);
    arstN <= 1'b0;
    repeat (12) @(posedge refClk);
    arstN <= 1'b1;
    repeat (3) @(posedge refClk);
  endtask

  function automatic logic [31:0] flipIn(logic [31:0] d, logic [1:0] m);
    logic [31:0] r;
    int g;
    g = (m == 2'h1) ? 8 : (m == 2'h2) ? 16 : 32;
    for (int i = 0; i < 32; i++) begin
      r[i] = d[(i / g) * g + g - 1 - i % g];
    end
    return (m == 2'h0) ? d : r;
  endfunction

  function automatic logic [31:0] szMask(logic [1:0] s);
    return (s == 2'h0) ? 32'hffffffff : (s == 2'h1) ? 32'h0000ffff :
           (s == 2'h2) ? 32'h000000ff : 32'h0000007f;
  endfunction

  // bitwise msb-first reference, independent of the byte engine
  function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] d,
                                       logic [7:0] ctl);
    logic [31:0] m;
    logic [31:0] x;
    int w;
    logic fb;
    m = szMask(ctl[4:3]);
    w = (ctl[4:3] == 2'h0) ? 32 : (ctl[4:3] == 2'h1) ? 16 :
        (ctl[4:3] == 2'h2) ? 8 : 7;
    x = flipIn(d, ctl[6:5]);
    c = c & m;
    for (int i = w - 1; i >= 0; i--) begin
      fb = c[w - 1] ^ x[i];
      c = (c << 1) & m;
      if (fb) c = c ^ (RST_GENERATOR_VALUE & m);
    end
    return c;
  endfunction

  function automatic logic [31:0] outVal(logic [31:0] c, logic [7:0] ctl);
    logic [31:0] r;
    c = c & szMask(ctl[4:3]);
    r = {<<{c}};
    return ctl[7] ? r : c;
  endfunction

  initial begin
    arstN = 1'b0;
    busSel = 1'b0;
    busWrite = 1'b0;
    busAddr = '0;
    busWdata = 32'h0;
    doReset();
    foreach (rows[i]) begin
      wr(OFF_CTRL, {24'h0, rows[i].ctl});
      wr(OFF_INIT, rows[i].init);
      acc = fold(rows[i].init, rows[i].d0, rows[i].ctl);
      acc = fold(acc, rows[i].d1, rows[i].ctl);
      wr(OFF_DATA, rows[i].d0);
      wr(OFF_DATA, rows[i].d1);
      rdChk("result", OFF_DATA, outVal(acc, rows[i].ctl));
      $display("row %0d done", i);
    end
    // second reset in mid-run, after registers were dirtied
    doReset();
    rdChk("data reset", OFF_DATA, 32'hffffffff);
    rdChk("spare reset", OFF_SPARE, 32'h0);
    rdChk("ctrl reset", OFF_CTRL, 32'h0);
    rdChk("init reset", OFF_INIT, 32'hffffffff);
    rdChk("generator_value reset", OFF_GENERATOR_VALUE, RST_GENERATOR_VALUE);
    rdChk("unmapped", 5'h0c, 32'h0);
    $display("reset test done");
    wr(OFF_SPARE, 32'h0000005a);
    rdChk("spare rw", OFF_SPARE, 32'h0000005a);
    // reload with size 7 and output flip: init masked to 7 bits
    wr(OFF_CTRL, 32'h000000f9);
    rdChk("reload", OFF_DATA, 32'hfe000000);
    rdChk("ctrl clear", OFF_CTRL, 32'h000000f8);
    rdChk("spare kept", OFF_SPARE, 32'h0000005a);
    $display("reload test done");
    // spare traffic while a word is folding must not disturb the result
    wr(OFF_CTRL, 32'h0);
    wr(OFF_INIT, 32'h0);
    wr(OFF_DATA, 32'h11223344);
    wr(OFF_SPARE, 32'h000000a5);
    rdChk("spare busy", OFF_SPARE, 32'h000000a5);
    acc = fold(32'h0, 32'h11223344, 8'h00);
    rdChk("fold spare", OFF_DATA, acc);
    wr(5'h0c, 32'hdeadbeef);
    rdChk("unmapped wr", OFF_DATA, acc);
    $display("spare test done");
    endSim();
  end
endmodule
`default_nettype wire
